/* timer_pkg.sv */
// Constants and types for the dual counter stopwatch timer
package timer_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned RATE_100HZ = 100;
  localparam int unsigned RATE_10HZ = 10;
  localparam int unsigned RATE_1HZ = 1;
  localparam int unsigned DIV_100HZ = CLK_HZ / RATE_100HZ;
  localparam int unsigned DIV_10HZ = CLK_HZ / RATE_10HZ;
  localparam int unsigned DIV_1HZ = CLK_HZ / RATE_1HZ;
  localparam int unsigned DIGITS = 4;
  localparam logic [3:0] DEC_MAX = 4'h9;
  localparam logic [3:0] SIX_MAX = 4'h5;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [1:0] RES_100HZ = 2'h0;
  localparam logic [1:0] RES_10HZ = 2'h1;
  localparam logic [1:0] RES_1HZ = 2'h2;
  localparam logic [1:0] RES_EXT = 2'h3;
  localparam logic [3:0] MOD6_DEFAULT = 4'h2;
  typedef enum logic [2:0] {
    FN_ELAPSED = 3'b000,
    FN_ACCUM = 3'b001,
    FN_SEQUENCE = 3'b010,
    FN_SPLIT = 3'b011,
    FN_PAUSE = 3'b100,
    FN_UPCMP = 3'b101,
    FN_DOWN = 3'b110
  } func_e;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_HOLD = 2'b10,
    ST_FINAL = 2'b11
  } run_e;
endpackage

/* stopwatch_timer.sv */
// Seven function dual counter stopwatch and timer core
// Notes on behaviour
// - Function 1: first start runs interval counter; next start shows elapsed interval.
// - Function 1: after final halt, a start shows the total elapsed counter.
// - Function 2: intervals timed; final halt then start shows accumulated total.
// - Function 3: each later start freezes the finished event time until next.
// - Function 3: final halt shows last event; next start shows total time.
// - Function 4: later starts refresh display; interval counter keeps accumulating.
// - Function 4: final halt stops accumulation and shows the run total.
// - Function 5: starts pause and resume; final halt then start shows totals.
// - Function 6: starts toggle the load until the count meets the preset; after that, starts are ignored until reset.
// - Function 6: reset ends the run and drops the load.
// - Function 7: counts down to zero after start, then switches load off.
// - External count clock in function 5 adds exactly one per pulse.
// - Reset clears the interval counter to zero.
// - Span is 99 minutes 59 seconds; tens of seconds roll at six.
// - Waiting state output is high in the idle and hold states.
// - Two select inputs pick 100 Hz, 10 Hz, 1 Hz or external count clock.
// - Stopwatch reset clears both counters in all functions but 6 and blanks the display in functions 1 to 5 only.
`timescale 1ns/1ps
module stopwatch_timer
  import timer_pkg::*;
#(
  parameter int unsigned DIV100 = DIV_100HZ,
  parameter int unsigned DIV10 = DIV_10HZ,
  parameter int unsigned DIV1 = DIV_1HZ,
  parameter logic [3:0] MOD6_MASK = MOD6_DEFAULT
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic enable_i,
  input wire logic [2:0] function_i,
  input wire logic [1:0] res_sel_i,
  input wire logic ext_count_i,
  input wire logic start_stop_i,
  input wire logic final_halt_i,
  input wire logic clear_i,
  input wire logic [15:0] preset_i,
  input wire logic preset_load_i,
  input wire logic compare_en_i,
  output logic [15:0] display_o,
  output logic blank_o,
  output logic waiting_o,
  output logic compare_o,
  output logic tick_o
);
  import timer_pkg::*;

  typedef struct packed {
    logic [1:0] ss_sync;
    logic [1:0] fh_sync;
    logic [1:0] cl_sync;
    logic [1:0] ext_sync;
    logic ss_prev;
    logic fh_prev;
    logic cl_prev;
    logic ext_prev;
    logic [26:0] div;
    logic tick;
    run_e st;
    logic show_total;
    logic blank;
    logic run1;
    logic run2;
    logic [15:0] cnt1;
    logic [15:0] cnt2;
    logic [15:0] disp;
    logic freeze;
    logic cmp;
  } state_s;

  state_s q, d;

  // Per digit roll limit: mask bit set makes that digit modulo six
  logic [3:0][3:0] lim;
  for (genvar g = 0; g < DIGITS; g++) begin : g_lim
    assign lim[g] = MOD6_MASK[g] ? SIX_MAX : DEC_MAX;
  end

  // One BCD step up or down; carry or borrow ripples through the digits
  function automatic logic [15:0] step(input logic [15:0] v, input logic [3:0][3:0] l,
    input logic down);
    logic [15:0] r;
    logic c;
    r = v;
    c = 1'b1;
    for (int i = 0; i < DIGITS; i++) begin
      if (c) begin
        if (down ? (v[i*4 +: 4] == 4'h0) : (v[i*4 +: 4] >= l[i])) begin
          r[i*4 +: 4] = down ? l[i] : 4'h0;
        end else begin
          r[i*4 +: 4] = down ? v[i*4 +: 4] - 4'h1 : v[i*4 +: 4] + 4'h1;
          c = 1'b0;
        end
      end
    end
    return r;
  endfunction

  logic ss_ev, fh_ev, cl_ev, ext_ev;
  logic [26:0] div_top;
  func_e fn;

  always_comb begin
    d = q;
    fn = func_e'(function_i);
    // Two flops then edge detect on the second stage only
    d.ss_sync = {q.ss_sync[0], start_stop_i};
    d.fh_sync = {q.fh_sync[0], final_halt_i};
    d.cl_sync = {q.cl_sync[0], clear_i};
    d.ext_sync = {q.ext_sync[0], ext_count_i};
    d.ss_prev = q.ss_sync[1];
    d.fh_prev = q.fh_sync[1];
    d.cl_prev = q.cl_sync[1];
    d.ext_prev = q.ext_sync[1];
    ss_ev = q.ss_sync[1] & ~q.ss_prev;
    fh_ev = q.fh_sync[1] & ~q.fh_prev;
    cl_ev = q.cl_sync[1] & ~q.cl_prev;
    ext_ev = q.ext_sync[1] & ~q.ext_prev;
    // Count tick selection
    case (res_sel_i)
      RES_100HZ: div_top = 27'(DIV100 - 1);
      RES_10HZ: div_top = 27'(DIV10 - 1);
      RES_1HZ: div_top = 27'(DIV1 - 1);
      default: div_top = '0;
    endcase
    if (res_sel_i == RES_EXT) begin
      d.div = '0;
      d.tick = ext_ev;
    end else if (q.div >= div_top) begin
      d.div = '0;
      d.tick = 1'b1;
    end else begin
      d.div = q.div + 27'd1;
      d.tick = 1'b0;
    end
    // Counting on the tick; sync start to tick_o avoids a short first count
    if (q.tick) begin
      if (q.run1) begin
        d.cnt1 = step(q.cnt1, lim, fn == FN_DOWN);
      end
      if (q.run2) begin
        d.cnt2 = step(q.cnt2, lim, 1'b0);
      end
    end
    if (preset_load_i && q.st == ST_IDLE && (fn == FN_UPCMP || fn == FN_DOWN)) begin
      d.cnt1 = preset_i;
    end
    // Comparison: up counter meets preset, or down count reaches zero
    if (fn == FN_UPCMP && q.run2 && compare_en_i && q.cnt2 == q.cnt1 && q.cnt1 != COUNT_ZERO) begin
      d.run2 = 1'b0;
      d.cmp = 1'b1;
      d.st = ST_HOLD;
      d.disp = q.cnt2;
    end
    if (fn == FN_DOWN && q.run1 && compare_en_i && q.cnt1 == COUNT_ZERO) begin
      d.run1 = 1'b0;
      d.cmp = 1'b1;
      d.st = ST_HOLD;
    end
    if (ss_ev) begin
      case (fn)
        FN_UPCMP: begin
          if (q.st != ST_HOLD || !q.cmp) begin
            d.run2 = ~q.run2;
            d.st = ST_RUN;
            d.cmp = 1'b0;
          end
        end
        FN_DOWN: begin
          if (q.st == ST_IDLE) begin
            d.run1 = 1'b1;
            d.st = ST_RUN;
            d.cmp = 1'b0;
          end
        end
        default: begin
          d.blank = 1'b0;
          case (q.st)
            ST_IDLE: begin
              d.st = ST_RUN;
              d.run1 = (fn != FN_SPLIT);
              d.run2 = 1'b1;
              d.cnt2 = COUNT_ZERO;
              d.freeze = 1'b0;
            end
            ST_RUN: begin
              d.disp = q.cnt2;
              d.freeze = 1'b1;
              if (fn == FN_SEQUENCE) begin
                d.cnt2 = COUNT_ZERO;
              end else if (fn != FN_SPLIT) begin
                d.run2 = 1'b0;
                d.st = ST_HOLD;
                if (fn == FN_ACCUM) begin
                  d.run1 = 1'b0;
                end
              end
              // Split keeps counting untouched, only the view is refreshed
            end
            ST_HOLD: begin
              d.st = ST_RUN;
              d.run2 = 1'b1;
              d.run1 = (fn != FN_SPLIT);
              d.freeze = 1'b0;
              if (fn != FN_PAUSE) begin
                d.cnt2 = COUNT_ZERO;
              end
            end
            ST_FINAL: begin
              if (fn != FN_SPLIT) begin
                d.show_total = ~q.show_total;
              end
            end
            default: d.st = ST_IDLE;
          endcase
        end
      endcase
    end
    if (fh_ev && q.st != ST_IDLE) begin
      d.run1 = 1'b0;
      d.run2 = 1'b0;
      d.st = (fn == FN_DOWN || fn == FN_UPCMP) ? ST_HOLD : ST_FINAL;
      d.freeze = 1'b0;
      d.show_total = 1'b0;
      if (fn == FN_SEQUENCE && q.freeze == 1'b0) begin
        d.disp = q.cnt2;
      end
    end
    if (cl_ev) begin
      d.st = ST_IDLE;
      d.run1 = 1'b0;
      d.run2 = 1'b0;
      d.cnt2 = COUNT_ZERO;
      d.cmp = 1'b0;
      d.freeze = 1'b0;
      d.show_total = 1'b0;
      d.disp = COUNT_ZERO;
      if (fn != FN_UPCMP) begin
        d.cnt1 = COUNT_ZERO;
      end
      d.blank = (fn != FN_UPCMP && fn != FN_DOWN);
    end
    // A clear must not be overwritten by a stale view of the counters
    if (!q.freeze && !cl_ev) begin
      if (q.show_total) begin
        d.disp = q.cnt1;
      end else if (fn == FN_DOWN || (fn == FN_UPCMP && !q.run2 && !q.cmp)) begin
        d.disp = q.cnt1;
      end else if (q.st != ST_IDLE) begin
        d.disp = q.cnt2;
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      q <= '{st: ST_IDLE, blank: 1'b1, default: '0};
    end else if (enable_i) begin
      q <= d;
    end
  end

  assign display_o = q.disp;
  assign blank_o = q.blank;
  assign waiting_o = (q.st == ST_IDLE) | (q.st == ST_HOLD);
  assign compare_o = q.cmp;
  assign tick_o = q.tick;

  a_clear_zeroes: assert property (@(posedge clk_i) disable iff (reset_i)
    enable_i && cl_ev |=> q.cnt2 == COUNT_ZERO && !compare_o)
    else $error("interval counter not cleared");
  a_cmp_drops: assert property (@(posedge clk_i) disable iff (reset_i)
    enable_i && cl_ev |=> !compare_o && !q.run2)
    else $error("load still on after reset event");
  a_digit_range: assert property (@(posedge clk_i) disable iff (reset_i)
    MOD6_MASK[1] |-> q.cnt2[7:4] <= SIX_MAX && q.cnt2[3:0] <= DEC_MAX)
    else $error("digit out of range");
  a_ext_step: assert property (@(posedge clk_i) disable iff (reset_i)
    enable_i && q.tick && q.run2 && q.cnt2[3:0] < lim[0] && !cl_ev && !ss_ev
      |=> q.cnt2[3:0] == $past(q.cnt2[3:0]) + 4'h1)
    else $error("count step not one");
  a_one_event: assert property (@(posedge clk_i) disable iff (reset_i)
    enable_i && ss_ev |=> !ss_ev)
    else $error("double start event");
  a_down_stop: assert property (@(posedge clk_i) disable iff (reset_i)
    enable_i && function_i == 3'h6 && q.run1 && compare_en_i && q.cnt1 == COUNT_ZERO
      && !cl_ev |=> compare_o && !q.run1)
    else $error("down count did not stop at zero");
  a_final_halts: assert property (@(posedge clk_i) disable iff (reset_i)
    enable_i && fh_ev && !cl_ev && q.st != ST_IDLE |=> !q.run1 && !q.run2)
    else $error("final halt did not stop counting");
  a_wait_light: assert property (@(posedge clk_i) disable iff (reset_i)
    enable_i && ss_ev && !cl_ev && q.st == ST_IDLE |=> !waiting_o)
    else $error("waiting output still high after start");
endmodule

/* button_pad.sv */
// Push-button and external count pulse source facing the timer core
`timescale 1ns/1ps
module button_pad (
  input wire logic clk_i,
  output logic start_stop_o,
  output logic final_halt_o,
  output logic clear_o,
  output logic ext_count_o,
  input wire logic [15:0] digits_i,
  input wire logic blank_i,
  output logic [27:0] seg_o
);
  // Switches idle low through their pull-downs
  initial begin
    start_stop_o = 1'b0;
    final_halt_o = 1'b0;
    clear_o = 1'b0;
    ext_count_o = 1'b0;
  end
  // One press: 0 start/stop, 1 final halt, else clear; held past the synchroniser
  task automatic press(input int k);
    @(posedge clk_i);
    if (k == 0) start_stop_o <= 1'b1;
    else if (k == 1) final_halt_o <= 1'b1;
    else clear_o <= 1'b1;
    repeat (3) @(posedge clk_i);
    start_stop_o <= 1'b0;
    final_halt_o <= 1'b0;
    clear_o <= 1'b0;
    repeat (5) @(posedge clk_i);
  endtask
  // Pulses only follow a settled start, so the first count is aligned
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk_i);
      ext_count_o <= 1'b1;
      repeat (3) @(posedge clk_i);
      ext_count_o <= 1'b0;
      repeat (2) @(posedge clk_i);
    end
    repeat (5) @(posedge clk_i);
  endtask
  // Display side: each BCD digit latched, then decoded to segments gfedcba
  logic [15:0] latch_q;
  always_ff @(posedge clk_i) begin
    latch_q <= digits_i;
  end
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      case (latch_q[i*4 +: 4])
        4'h0: seg_o[i*7 +: 7] = 7'h3f;
        4'h1: seg_o[i*7 +: 7] = 7'h06;
        4'h2: seg_o[i*7 +: 7] = 7'h5b;
        4'h3: seg_o[i*7 +: 7] = 7'h4f;
        4'h4: seg_o[i*7 +: 7] = 7'h66;
        4'h5: seg_o[i*7 +: 7] = 7'h6d;
        4'h6: seg_o[i*7 +: 7] = 7'h7d;
        4'h7: seg_o[i*7 +: 7] = 7'h07;
        4'h8: seg_o[i*7 +: 7] = 7'h7f;
        4'h9: seg_o[i*7 +: 7] = 7'h6f;
        default: seg_o[i*7 +: 7] = 7'h00;
      endcase
      if (blank_i) begin
        seg_o[i*7 +: 7] = 7'h00;
      end
    end
  end
endmodule

/* tb_top.sv */
// Self-checking bench for the stopwatch timer core
`timescale 1ns/1ps
module tb_top;
  import timer_pkg::*;
  logic clk_i, reset_i, preset_load_i, compare_en_i;
  logic [2:0] function_i;
  logic [15:0] preset_i, display_o;
  logic ss, fh, clr, ext, blank_o, waiting_o, compare_o, tick_o, enable_i;
  logic [1:0] res_sel_i;
  logic [27:0] seg;
  int n_fail = 0;
  int total_checks = 0;
  // Short divider periods keep the internal tick scenario brief
  localparam int unsigned T_DIV [3] = '{4, 8, 16};
  stopwatch_timer #(.DIV100(T_DIV[0]), .DIV10(T_DIV[1]), .DIV1(T_DIV[2])) u_dut (
    .clk_i(clk_i), .reset_i(reset_i), .enable_i(enable_i), .function_i(function_i),
    .res_sel_i(res_sel_i), .ext_count_i(ext), .start_stop_i(ss), .final_halt_i(fh),
    .clear_i(clr), .preset_i(preset_i), .preset_load_i(preset_load_i),
    .compare_en_i(compare_en_i), .display_o(display_o), .blank_o(blank_o),
    .waiting_o(waiting_o), .compare_o(compare_o), .tick_o(tick_o));
  button_pad u_pad (.clk_i(clk_i), .start_stop_o(ss), .final_halt_o(fh),
    .clear_o(clr), .ext_count_o(ext), .digits_i(display_o), .blank_i(blank_o),
    .seg_o(seg));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic do_reset(input func_e f, input int n);
    @(posedge clk_i);
    function_i <= f;
    reset_i <= 1'b1;
    repeat (n) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    check(display_o, COUNT_ZERO);
    check(16'({blank_o, waiting_o, compare_o}), 16'h0006);
  endtask
  // Interval, hold, then total after the final halt
  task automatic t_elapsed();
    do_reset(FN_ELAPSED, 2);
    u_pad.press(0);
    u_pad.pulses(5);
    check(16'(waiting_o), 16'h0000);
    u_pad.press(0);
    check(display_o, 16'h0005);
    check(16'(waiting_o), 16'h0001);
    check(16'(blank_o), 16'h0000);
    check(16'(seg[6:0]), 16'h006d);
    u_pad.pulses(3);
    check(display_o, 16'h0005);
    u_pad.press(0);
    u_pad.pulses(2);
    u_pad.press(1);
    check(display_o, 16'h0002);
    u_pad.press(0);
    check(display_o, 16'h0010);
    u_pad.press(2);
    check(display_o, COUNT_ZERO);
    check(16'(blank_o), 16'h0001);
    $display("test elapsed done");
  endtask
  // Counter 1 pauses with counter 2, so the total is accumulated time
  task automatic t_accum();
    do_reset(FN_ACCUM, 2);
    u_pad.press(0);
    u_pad.pulses(3);
    u_pad.press(0);
    u_pad.pulses(2);
    check(display_o, 16'h0003);
    u_pad.press(0);
    u_pad.pulses(4);
    check(display_o, 16'h0004);
    u_pad.press(1);
    u_pad.press(0);
    check(display_o, 16'h0007);
    $display("test accum done");
  endtask
  // Event times frozen one at a time, then last event and total
  task automatic t_sequence();
    do_reset(FN_SEQUENCE, 2);
    u_pad.press(0);
    u_pad.pulses(3);
    u_pad.press(0);
    u_pad.pulses(2);
    check(display_o, 16'h0003);
    u_pad.press(0);
    check(display_o, 16'h0002);
    u_pad.pulses(4);
    u_pad.press(1);
    check(display_o, 16'h0004);
    u_pad.press(0);
    check(display_o, 16'h0009);
    $display("test sequence done");
  endtask
  // Split view refreshes without clearing; final halt stops the run
  task automatic t_split();
    do_reset(FN_SPLIT, 2);
    u_pad.press(0);
    u_pad.pulses(3);
    u_pad.press(0);
    u_pad.pulses(2);
    check(display_o, 16'h0003);
    u_pad.press(0);
    check(display_o, 16'h0005);
    u_pad.pulses(1);
    u_pad.press(1);
    u_pad.pulses(2);
    check(display_o, 16'h0006);
    $display("test split done");
  endtask
  // Enable low freezes all state, so pulses in that time are lost
  task automatic t_freeze();
    do_reset(FN_PAUSE, 2);
    u_pad.press(0);
    u_pad.pulses(2);
    enable_i <= 1'b0;
    u_pad.pulses(3);
    check(display_o, 16'h0002);
    enable_i <= 1'b1;
    u_pad.pulses(1);
    check(display_o, 16'h0003);
    $display("test freeze done");
  endtask
  // Internal tick: one high cycle per divider period for each select code
  task automatic t_rates();
    logic [15:0] n;
    do_reset(FN_ELAPSED, 2);
    for (int r = 0; r < 3; r++) begin
      res_sel_i <= 2'(r);
      repeat (20) @(negedge clk_i);
      n = 16'h0000;
      repeat (48) begin
        @(negedge clk_i);
        n = n + 16'(tick_o);
      end
      check(n, 16'(48 / T_DIV[r]));
      @(posedge clk_i);
    end
    res_sel_i <= RES_EXT;
    $display("test rates done");
  endtask
  // Pause and resume, external pulses, base-six rollover and totals
  task automatic t_pause();
    do_reset(FN_PAUSE, 8);
    u_pad.press(0);
    u_pad.pulses(12);
    check(display_o, 16'h0012);
    u_pad.press(0);
    u_pad.pulses(4);
    check(display_o, 16'h0012);
    u_pad.press(0);
    u_pad.pulses(587);
    check(display_o, 16'h0959);
    u_pad.pulses(1);
    check(display_o, 16'h1000);
    u_pad.press(1);
    check(display_o, 16'h1000);
    u_pad.press(0);
    check(display_o, 16'h1004);
    $display("test pause done");
  endtask
  // Preset compare up count, down count to zero, reset drops the load
  task automatic t_compare(input func_e f, input logic [15:0] p, input int n);
    do_reset(f, 2);
    preset_i <= p;
    compare_en_i <= 1'b1;
    preset_load_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    preset_load_i <= 1'b0;
    u_pad.press(0);
    u_pad.pulses(n - 1);
    check(16'(compare_o), 16'h0000);
    u_pad.pulses(1);
    check(16'(compare_o), 16'h0001);
    if (f == FN_UPCMP) begin
      u_pad.press(2);
      check(16'(compare_o), 16'h0000);
      check(display_o, p);
    end
    compare_en_i <= 1'b0;
    $display("test compare %0d done", f);
  endtask
  initial begin
    reset_i = 1'b1;
    enable_i = 1'b1;
    res_sel_i = RES_EXT;
    function_i = FN_ELAPSED;
    preset_i = COUNT_ZERO;
    preset_load_i = 1'b0;
    compare_en_i = 1'b0;
    repeat (8) @(posedge clk_i);
    reset_i <= 1'b0;
    t_elapsed();
    t_accum();
    t_sequence();
    t_split();
    t_pause();
    t_freeze();
    t_rates();
    t_compare(FN_UPCMP, 16'h0003, 3);
    t_compare(FN_DOWN, 16'h0002, 2);
    close_out();
  end
  initial begin
    #300us;
    n_fail++;
    close_out();
  end
endmodule
